// ===== cbbm_cfg.svh
// Constants for the branch, bit and addressing decoder of the processor core.
// Notes on behaviour
// RULE1 - Bit ops two bytes; carry-only ops one.
// RULE2 - Carry jumps: two bytes, 2 or 4 cycles.
// RULE3 - Bit jumps: three bytes, 3/5; clear on branch.
// RULE4 - Jumps 4, long 5, returns 6 cycles.
// RULE5 - Accumulator zero jumps: two bytes, 2/4.
// RULE6 - Compare jumps three bytes; 3/5, indirect 4/6.
// RULE7 - Decrement jumps: register 2/4, direct 3/5.
// RULE8 - No-operation and spare opcode: one byte, cycle.
// RULE9 - Relative targets: next address plus signed offset.
// RULE10 - Absolute targets stay in the same 2K page.
// RULE11 - Direct below 0x80 is RAM, else registers.
// RULE12 - 64K program space; above 0xFBFF reserved.
// RULE13 - Store enable steers external writes to flash.
// RULE14 - 256 RAM bytes; low half direct and indirect.
// RULE15 - Above 0x7F: indirect upper RAM, direct registers.
// RULE16 - Four register banks chosen by status bits 3-4.
// RULE17 - Indirect pointer is register zero or one.
// RULE18 - Bytes 0x20-0x2F hold bits 0x00-0x7F.
// RULE19 - Bit access only for bit instructions.
// RULE20 - Short count when failing, long when taken.
`ifndef CBBM_CFG_SVH
`define CBBM_CFG_SVH
`define CBBM_OP_NOP 8'h00
`define CBBM_OP_SPARE 8'ha5
`define CBBM_OP_CLRC 8'hc3
`define CBBM_OP_SETBC 8'hd3
`define CBBM_OP_CPLC 8'hb3
`define CBBM_OP_CLRB 8'hc2
`define CBBM_OP_SETBB 8'hd2
`define CBBM_OP_CPLB 8'hb2
`define CBBM_OP_ANLB 8'h82
`define CBBM_OP_ANLNB 8'hb0
`define CBBM_OP_ORLB 8'h72
`define CBBM_OP_ORLNB 8'ha0
`define CBBM_OP_MOVCB 8'ha2
`define CBBM_OP_MOVBC 8'h92
`define CBBM_OP_JC 8'h40
`define CBBM_OP_JNC 8'h50
`define CBBM_OP_JB 8'h20
`define CBBM_OP_JNB 8'h30
`define CBBM_OP_JBTC 8'h10
`define CBBM_OP_LONG_CALL 8'h12
`define CBBM_OP_LJUMP 8'h02
`define CBBM_OP_RET 8'h22
`define CBBM_OP_IRET 8'h32
`define CBBM_OP_SHORT 8'h80
`define CBBM_OP_JMPA 8'h73
`define CBBM_OP_JZ 8'h60
`define CBBM_OP_JNZ 8'h70
`define CBBM_OP_CMPAD 8'hb5
`define CBBM_OP_CMPAI 8'hb4
`define CBBM_OP_CMPI0 8'hb6
`define CBBM_OP_CMPI1 8'hb7
`define CBBM_OP_CMPR_HI 5'h17
`define CBBM_OP_DECR_HI 5'h1b
`define CBBM_OP_DECD 8'hd5
`define CBBM_OP_ABS_LO 4'h1
`define CBBM_LEN1 2'h1
`define CBBM_LEN2 2'h2
`define CBBM_LEN3 2'h3
`define CBBM_CYC1 3'h1
`define CBBM_CYC2 3'h2
`define CBBM_CYC3 3'h3
`define CBBM_CYC4 3'h4
`define CBBM_CYC5 3'h5
`define CBBM_CYC6 3'h6
`define CBBM_BR_EXTRA 3'h2
`define CBBM_PC_TOP 16'hfbff
`define CBBM_BIT_BASE 8'h20
`define CBBM_PSW_BANK_HI 4
`define CBBM_PSW_BANK_LO 3
`endif

// ===== cbbm_pkg.sv
// Types shared by the branch, bit and addressing decoder.
package cbbm_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } cbbm_state_t;
  typedef enum logic [1:0] {
    SP_NONE = 2'h0,
    SP_RAM_LOW = 2'h1,
    SP_SFR = 2'h2,
    SP_RAM_UP = 2'h3
  } cbbm_space_t;
endpackage : cbbm_pkg

// ===== cbbm_core.sv
// Decoder for bit, branch and operand addressing of the processor core.
`timescale 1ns/10ps
`include "cbbm_cfg.svh"
module cbbm_core
  import cbbm_pkg::*;
(
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic NRST,
  // Instruction presented for execution.
  input wire logic START,
  input wire logic [7:0] OPCODE,
  input wire logic [7:0] OP1,
  input wire logic [7:0] OP2,
  input wire logic [15:0] PC,
  // Processor state read for the decision.
  input wire logic CARRY,
  input wire logic [7:0] ACC,
  input wire logic [7:0] PROGRAM_STATUS_WORD,
  input wire logic [15:0] DATA_POINTER,
  input wire logic [15:0] RET_ADDR,
  input wire logic BIT_VAL,
  input wire logic [7:0] OPERAND,
  input wire logic [7:0] PTR_VAL,
  // External move write request.
  input wire logic XMOVE_WR,
  input wire logic PROGRAM_STORE_WE,
  // Decode results.
  output logic BUSY,
  output logic DONE,
  output logic DECODED,
  output logic [1:0] INSTR_LEN,
  output logic [2:0] CYCLES,
  output logic TAKEN,
  output logic [15:0] NEXT_PC,
  output logic PC_RESERVED,
  // Operand addressing.
  output logic [7:0] OPND_ADDR,
  output logic [1:0] OPND_SPACE,
  output logic [7:0] PTR_ADDR,
  output logic BIT_ACCESS,
  output logic [2:0] BIT_POS,
  output logic CLR_BIT,
  output logic [7:0] WB_DATA,
  // Write steering.
  output logic FLASH_WR,
  output logic XDATA_WR
);
  cbbm_state_t state_ff;
  logic [2:0] cnt_ff;
  logic [15:0] seq1, seq2, seq3, rel2, rel3;
  logic [1:0] bank;
  logic [7:0] reg_addr, ind_ptr, wb_dec;
  logic d_known, d_taken, d_bit, d_clr;
  logic [1:0] d_len;
  logic [2:0] d_cyc;
  logic [15:0] d_tgt;
  logic [7:0] d_addr, d_wb;
  cbbm_space_t d_space;
  logic accept;

  assign accept = START && (state_ff == ST_IDLE);
  assign seq1 = PC + 16'h0001;
  assign seq2 = PC + 16'h0002;
  assign seq3 = PC + 16'h0003;
  assign rel2 = seq2 + {{8{OP1[7]}}, OP1}; // see RULE9
  assign rel3 = seq3 + {{8{OP2[7]}}, OP2}; // see RULE9
  assign bank = PROGRAM_STATUS_WORD[`CBBM_PSW_BANK_HI:`CBBM_PSW_BANK_LO]; // see RULE16
  assign reg_addr = {3'h0, bank, OPCODE[2:0]}; // see RULE16
  assign ind_ptr = {3'h0, bank, 2'h0, OPCODE[0]}; // see RULE17
  assign wb_dec = OPERAND - 8'h01;

  always_comb
  begin
    d_known = 1'b1;
    d_len = `CBBM_LEN1;
    d_cyc = `CBBM_CYC1;
    d_taken = 1'b0;
    d_tgt = seq1;
    d_bit = 1'b0;
    d_clr = 1'b0;
    d_addr = 8'h00;
    d_space = SP_NONE;
    d_wb = 8'h00;
    case (OPCODE)
      `CBBM_OP_NOP, `CBBM_OP_SPARE, `CBBM_OP_CLRC, `CBBM_OP_SETBC, `CBBM_OP_CPLC:
      begin
        d_len = `CBBM_LEN1; // see RULE1 see RULE8
      end
      `CBBM_OP_CLRB, `CBBM_OP_SETBB, `CBBM_OP_CPLB, `CBBM_OP_ANLB, `CBBM_OP_ANLNB,
      `CBBM_OP_ORLB, `CBBM_OP_ORLNB, `CBBM_OP_MOVCB, `CBBM_OP_MOVBC:
      begin
        d_len = `CBBM_LEN2; // see RULE1
        d_cyc = `CBBM_CYC2;
        d_tgt = seq2;
        d_bit = 1'b1; // see RULE19
      end
      `CBBM_OP_JC, `CBBM_OP_JNC:
      begin
        d_len = `CBBM_LEN2; // see RULE2
        d_cyc = `CBBM_CYC2;
        d_tgt = seq2;
        d_taken = CARRY ^ (OPCODE == `CBBM_OP_JNC);
        if (d_taken)
          d_tgt = rel2;
      end
      `CBBM_OP_JB, `CBBM_OP_JNB, `CBBM_OP_JBTC:
      begin
        d_len = `CBBM_LEN3; // see RULE3
        d_cyc = `CBBM_CYC3;
        d_tgt = seq3;
        d_bit = 1'b1; // see RULE19
        d_taken = BIT_VAL ^ (OPCODE == `CBBM_OP_JNB);
        d_clr = d_taken && (OPCODE == `CBBM_OP_JBTC); // see RULE3
        if (d_taken)
          d_tgt = rel3;
      end
      `CBBM_OP_LONG_CALL, `CBBM_OP_LJUMP:
      begin
        d_len = `CBBM_LEN3;
        d_cyc = `CBBM_CYC5; // see RULE4
        d_taken = 1'b1;
        d_tgt = {OP1, OP2};
      end
      `CBBM_OP_RET, `CBBM_OP_IRET:
      begin
        d_cyc = `CBBM_CYC6; // see RULE4
        d_taken = 1'b1;
        d_tgt = RET_ADDR;
      end
      `CBBM_OP_SHORT:
      begin
        d_len = `CBBM_LEN2;
        d_cyc = `CBBM_CYC4; // see RULE4
        d_taken = 1'b1;
        d_tgt = rel2;
      end
      `CBBM_OP_JMPA:
      begin
        d_cyc = `CBBM_CYC4; // see RULE4
        d_taken = 1'b1;
        d_tgt = DATA_POINTER + {8'h00, ACC};
      end
      `CBBM_OP_JZ, `CBBM_OP_JNZ:
      begin
        d_len = `CBBM_LEN2; // see RULE5
        d_cyc = `CBBM_CYC2;
        d_tgt = seq2;
        d_taken = (ACC == 8'h00) ^ (OPCODE == `CBBM_OP_JNZ);
        if (d_taken)
          d_tgt = rel2;
      end
      `CBBM_OP_CMPAD, `CBBM_OP_CMPAI:
      begin
        d_len = `CBBM_LEN3; // see RULE6
        d_cyc = `CBBM_CYC3;
        d_tgt = seq3;
        if (OPCODE == `CBBM_OP_CMPAD)
        begin
          d_addr = OP1;
          d_space = OP1[7] ? SP_SFR : SP_RAM_LOW; // see RULE11
          d_taken = ACC != OPERAND;
        end
        else
          d_taken = ACC != OP1;
        if (d_taken)
          d_tgt = rel3;
      end
      `CBBM_OP_CMPI0, `CBBM_OP_CMPI1:
      begin
        d_len = `CBBM_LEN3;
        d_cyc = `CBBM_CYC4; // see RULE6
        d_tgt = seq3;
        d_addr = PTR_VAL;
        d_space = PTR_VAL[7] ? SP_RAM_UP : SP_RAM_LOW; // see RULE14 see RULE15
        d_taken = OPERAND != OP1;
        if (d_taken)
          d_tgt = rel3;
      end
      `CBBM_OP_DECD:
      begin
        d_len = `CBBM_LEN3;
        d_cyc = `CBBM_CYC3; // see RULE7
        d_tgt = seq3;
        d_addr = OP1;
        d_space = OP1[7] ? SP_SFR : SP_RAM_LOW; // see RULE11 see RULE15
        d_wb = wb_dec;
        d_taken = wb_dec != 8'h00;
        if (d_taken)
          d_tgt = rel3;
      end
      default:
      begin
        if (OPCODE[7:3] == `CBBM_OP_CMPR_HI)
        begin
          d_len = `CBBM_LEN3; // see RULE6
          d_cyc = `CBBM_CYC3;
          d_tgt = seq3;
          d_addr = reg_addr;
          d_space = SP_RAM_LOW;
          d_taken = OPERAND != OP1;
          if (d_taken)
            d_tgt = rel3;
        end
        else if (OPCODE[7:3] == `CBBM_OP_DECR_HI)
        begin
          d_len = `CBBM_LEN2;
          d_cyc = `CBBM_CYC2; // see RULE7
          d_tgt = seq2;
          d_addr = reg_addr;
          d_space = SP_RAM_LOW;
          d_wb = wb_dec;
          d_taken = wb_dec != 8'h00;
          if (d_taken)
            d_tgt = rel2;
        end
        else if (OPCODE[3:0] == `CBBM_OP_ABS_LO)
        begin
          d_len = `CBBM_LEN2;
          d_cyc = `CBBM_CYC4; // see RULE4
          d_taken = 1'b1;
          d_tgt = {seq2[15:11], OPCODE[7:5], OP1}; // see RULE10
        end
        else
          d_known = 1'b0;
      end
    endcase
    if (d_bit)
    begin
      d_addr = OP1[7] ? {OP1[7:3], 3'h0} : `CBBM_BIT_BASE + {4'h0, OP1[6:3]}; // see RULE18
      d_space = OP1[7] ? SP_SFR : SP_RAM_LOW;
    end
    if (d_taken && (d_cyc != `CBBM_CYC4 || OPCODE[7:1] == 7'h5b)
        && d_len != `CBBM_LEN1 && OPCODE[3:0] != `CBBM_OP_ABS_LO
        && OPCODE != `CBBM_OP_SHORT && OPCODE != `CBBM_OP_LONG_CALL
        && OPCODE != `CBBM_OP_LJUMP)
      d_cyc = d_cyc + `CBBM_BR_EXTRA; // see RULE20
  end

  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= 3'h0;
      DONE <= 1'b0;
      BUSY <= 1'b0;
    end
    else
    begin
      DONE <= 1'b0;
      unique case (state_ff)
        ST_IDLE:
        begin
          if (accept)
          begin
            cnt_ff <= d_cyc - 3'h1;
            if (d_cyc == `CBBM_CYC1)
              DONE <= 1'b1;
            else
            begin
              state_ff <= ST_EXEC;
              BUSY <= 1'b1;
            end
          end
        end
        ST_EXEC:
        begin
          cnt_ff <= cnt_ff - 3'h1;
          if (cnt_ff == 3'h1)
          begin
            DONE <= 1'b1;
            BUSY <= 1'b0;
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      DECODED <= 1'b0;
      INSTR_LEN <= `CBBM_LEN1;
      CYCLES <= `CBBM_CYC1;
      TAKEN <= 1'b0;
      NEXT_PC <= 16'h0000;
      PC_RESERVED <= 1'b0;
      OPND_ADDR <= 8'h00;
      OPND_SPACE <= SP_NONE;
      PTR_ADDR <= 8'h00;
      BIT_ACCESS <= 1'b0;
      BIT_POS <= 3'h0;
      CLR_BIT <= 1'b0;
      WB_DATA <= 8'h00;
    end
    else if (accept)
    begin
      DECODED <= d_known;
      INSTR_LEN <= d_len;
      CYCLES <= d_cyc;
      TAKEN <= d_taken;
      NEXT_PC <= d_tgt;
      PC_RESERVED <= d_tgt > `CBBM_PC_TOP; // see RULE12
      OPND_ADDR <= d_addr;
      OPND_SPACE <= d_space;
      PTR_ADDR <= ind_ptr; // see RULE17
      BIT_ACCESS <= d_bit; // see RULE19
      BIT_POS <= OP1[2:0];
      CLR_BIT <= d_clr;
      WB_DATA <= d_wb;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      FLASH_WR <= 1'b0;
      XDATA_WR <= 1'b0;
    end
    else
    begin
      FLASH_WR <= XMOVE_WR && PROGRAM_STORE_WE; // see RULE13
      XDATA_WR <= XMOVE_WR && !PROGRAM_STORE_WE;
    end
  end

  logic [3:0] age_ff;
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
      age_ff <= 4'h0;
    else if (accept)
      age_ff <= 4'h1;
    else if (age_ff != 4'h0)
      age_ff <= age_ff + 4'h1;
  end

  sequence s_start(logic [7:0] op);
    accept && OPCODE == op;
  endsequence

  AST_DONE_COUNT: assert property (@(posedge SYS_CLK) disable iff (!NRST) // see RULE20
    DONE |-> age_ff == {1'b0, CYCLES}) else $error("done at wrong cycle");
  AST_NOP_SPARE: assert property (@(posedge SYS_CLK) disable iff (!NRST) // see RULE8
    s_start(`CBBM_OP_SPARE) |=> DONE && INSTR_LEN == 2'h1 && CYCLES == 3'h1)
    else $error("spare opcode not a no-operation");
  AST_CARRY_JUMP: assert property (@(posedge SYS_CLK) disable iff (!NRST) // see RULE2
    s_start(`CBBM_OP_JC) |=> TAKEN == $past(CARRY) && CYCLES == (TAKEN ? 3'h4 : 3'h2)
    ##1 DONE == !TAKEN) else $error("carry jump timing wrong");
  AST_BIT_CLEAR: assert property (@(posedge SYS_CLK) disable iff (!NRST) // see RULE3
    s_start(`CBBM_OP_JBTC) ##1 TAKEN |-> CLR_BIT && CYCLES == 3'h5 && INSTR_LEN == 2'h3)
    else $error("bit jump did not clear");
  AST_LONG_CALL: assert property (@(posedge SYS_CLK) disable iff (!NRST) // see RULE4
    s_start(`CBBM_OP_LONG_CALL) |=> BUSY [*4] ##1 DONE) else $error("long call not 5 cycles");
  AST_ABS_PAGE: assert property (@(posedge SYS_CLK) disable iff (!NRST) // see RULE10
    accept && OPCODE[3:0] == 4'h1 && d_known |=> NEXT_PC[15:11] == $past(seq2[15:11]))
    else $error("absolute target left page");
  AST_CMP_IND: assert property (@(posedge SYS_CLK) disable iff (!NRST) // see RULE6
    s_start(`CBBM_OP_CMPI1) |=> OPND_SPACE == ($past(PTR_VAL[7]) ? SP_RAM_UP : SP_RAM_LOW)
    && CYCLES == (TAKEN ? 3'h6 : 3'h4)) else $error("indirect compare wrong");
  AST_BIT_MAP: assert property (@(posedge SYS_CLK) disable iff (!NRST) // see RULE18
    s_start(`CBBM_OP_MOVCB) ##0 !OP1[7] |=> BIT_ACCESS
    && OPND_ADDR == 8'h20 + {4'h0, $past(OP1[6:3])}) else $error("bit map wrong");
  AST_DIRECT_SFR: assert property (@(posedge SYS_CLK) disable iff (!NRST) // see RULE11
    s_start(`CBBM_OP_DECD) |=> OPND_SPACE == ($past(OP1[7]) ? SP_SFR : SP_RAM_LOW))
    else $error("direct space wrong");
  AST_FLASH_STEER: assert property (@(posedge SYS_CLK) disable iff (!NRST) // see RULE13
    XMOVE_WR && PROGRAM_STORE_WE |=> FLASH_WR && !XDATA_WR) else $error("write not steered");
  AST_BANK_REG: assert property (@(posedge SYS_CLK) disable iff (!NRST) // see RULE16
    accept && OPCODE[7:3] == 5'h1b |=> OPND_ADDR[4:3] == $past(bank)
    && OPND_ADDR[7:5] == 3'h0) else $error("bank select wrong");
endmodule : cbbm_core

// ===== cbbm_mem_model.sv
// Behavioural data memory and write sink facing the decoder.
`timescale 1ns/10ps
module cbbm_mem_model
  import cbbm_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Byte and bit reads.
  input wire logic [7:0] addr,
  input wire logic [7:0] bit_addr,
  output logic [7:0] rdata,
  output logic rbit,
  // Write strobes and their tallies.
  input wire logic flash_wr,
  input wire logic xdata_wr,
  output logic [15:0] flash_cnt,
  output logic [15:0] xdata_cnt
);
  logic [7:0] ram [256];
  logic [15:0] flash_cnt_ff;
  logic [15:0] xdata_cnt_ff;
  // A fixed fill pattern lets the bench steer operand values by address.
  initial
  begin
    for (int i = 0; i < 256; i++)
      ram[i] = 8'(i) ^ 8'h5a;
  end
  assign rdata = ram[addr];
  // Bits above 0x7f sit in the register space, which this model does not hold.
  assign rbit = bit_addr[7] ? bit_addr[0] : ram[8'h20 + bit_addr[6:3]][bit_addr[2:0]];
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flash_cnt_ff <= 16'h0000;
      xdata_cnt_ff <= 16'h0000;
    end
    else
    begin
      flash_cnt_ff <= flash_cnt_ff + 16'(flash_wr);
      xdata_cnt_ff <= xdata_cnt_ff + 16'(xdata_wr);
    end
  end
  assign flash_cnt = flash_cnt_ff;
  assign xdata_cnt = xdata_cnt_ff;
endmodule : cbbm_mem_model

// ===== cpu_branch_bit_memory_addressing_bench.sv
// Self-checking bench for the branch, bit and addressing decoder.
`timescale 1ns/10ps
module cpu_branch_bit_memory_addressing_bench
  import cbbm_pkg::*;
;
  typedef struct {
    logic dec, tc, tk, clr, ba, ock, pck, wck;
    logic [1:0] len, sp;
    logic [2:0] cyc, bp;
    logic [15:0] npc;
    logic [7:0] oa, pa, wb;
    time t0;
  } cbbm_exp_t;
  logic sys_clk = 1'b0, nrst = 1'b0, start = 1'b0, carry = 1'b0, go = 1'b0;
  logic xw = 1'b0, we = 1'b0, xw_q = 1'b0, we_q = 1'b0;
  logic [7:0] opcode = 8'h00, op1 = 8'h00, op2 = 8'h00, acc = 8'h00, program_status_word = 8'h00;
  logic [7:0] ptr = 8'h00, maddr = 8'h00;
  logic [15:0] pc = 16'h0000, dp = 16'h0000, ra = 16'h0000, nf = 16'h0000, nxd = 16'h0000;
  logic busy, done, decoded, tk, pres, bacc, clrb, fwr, xwr, bitv;
  logic [1:0] len, space;
  logic [2:0] cyc, bpos;
  logic [15:0] npc, fcnt, xcnt;
  logic [7:0] oaddr, paddr, wb, operand;
  logic [31:0] seed = 32'h8957;
  int errors = 0;
  int total_checks = 0;
  cbbm_exp_t q[$];
  cbbm_exp_t m;
  logic [7:0] tbl [37] = '{8'h00, 8'ha5, 8'hc3, 8'hd3, 8'hb3, 8'hc2, 8'hd2, 8'hb2, 8'h82,
    8'hb0, 8'h72, 8'ha0, 8'ha2, 8'h92, 8'h40, 8'h50, 8'h20, 8'h30, 8'h10, 8'h01, 8'h11,
    8'h12, 8'h02, 8'h22, 8'h32, 8'h80, 8'h73, 8'h60, 8'h70, 8'hb5, 8'hb4, 8'hb8, 8'hb6,
    8'hb7, 8'hd8, 8'hd5, 8'h04};

  cbbm_core i_dut (.SYS_CLK(sys_clk), .NRST(nrst), .START(start), .OPCODE(opcode),
    .OP1(op1), .OP2(op2), .PC(pc), .CARRY(carry), .ACC(acc), .PROGRAM_STATUS_WORD(program_status_word),
    .DATA_POINTER(dp), .RET_ADDR(ra), .BIT_VAL(bitv), .OPERAND(operand), .PTR_VAL(ptr),
    .XMOVE_WR(xw), .PROGRAM_STORE_WE(we), .BUSY(busy), .DONE(done), .DECODED(decoded),
    .INSTR_LEN(len), .CYCLES(cyc), .TAKEN(tk), .NEXT_PC(npc), .PC_RESERVED(pres),
    .OPND_ADDR(oaddr), .OPND_SPACE(space), .PTR_ADDR(paddr), .BIT_ACCESS(bacc),
    .BIT_POS(bpos), .CLR_BIT(clrb), .WB_DATA(wb), .FLASH_WR(fwr), .XDATA_WR(xwr));
  cbbm_mem_model i_mem (.clk(sys_clk), .rst_n(nrst), .addr(maddr), .bit_addr(op1),
    .rdata(operand), .rbit(bitv), .flash_wr(fwr), .xdata_wr(xwr), .flash_cnt(fcnt),
    .xdata_cnt(xcnt));

  always #4 sys_clk = ~sys_clk;

  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  // Conditional branch: short count when failing, two more when taken.
  task automatic cj(input logic [1:0] l, input logic [2:0] b, input logic [7:0] r,
    input logic c, input logic t, inout cbbm_exp_t e);
    e.len = l;
    e.tc = t;
    e.tk = c;
    e.cyc = c ? b + 3'h2 : b;
    e.npc = c ? pc + 16'(l) + {{8{r[7]}}, r} : pc + 16'(l);
  endtask : cj

  task automatic bitop(inout cbbm_exp_t e);
    e.ba = 1'b1;
    e.ock = 1'b1;
    e.oa = op1[7] ? {op1[7:3], 3'h0} : 8'h20 + op1[6:3];
    e.sp = op1[7] ? 2'h2 : 2'h1;
    e.bp = op1[2:0];
  endtask : bitop

  task automatic issue(input logic [7:0] op_in);
    cbbm_exp_t e;
    logic [7:0] op;
    logic [31:0] r;
    int n;
    op = op_in;
    if (op[3:0] == 4'h1)
      op[7:5] = 3'(xorshift());
    if (op[7:3] == 5'h17 || op[7:3] == 5'h1b)
      op[2:0] = 3'(xorshift());
    r = xorshift();
    opcode = op;
    {op1, op2, program_status_word} = 24'(xorshift());
    {pc, dp} = xorshift();
    ra = 16'(xorshift());
    ptr = 8'(xorshift());
    carry = r[5];
    maddr = r[1:0] == 2'h0 ? op1 ^ 8'h5a : r[1:0] == 2'h1 ? 8'h5b : 8'(r >> 8);
    acc = r[3] ? 8'h00 : r[2] ? op1 : 8'(r >> 16);
    start = 1'b1;
    #1;
    e = '{dec: 1'b1, len: 2'h1, cyc: 3'h1, npc: pc + 16'h1, default: '0};
    case (op) inside
      8'h00, 8'ha5, 8'hc3, 8'hd3, 8'hb3: ;
      8'hc2, 8'hd2, 8'hb2, 8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2, 8'h92:
      begin
        cj(2'h2, 3'h2, 8'h00, 1'b0, 1'b0, e);
        bitop(e);
      end
      8'h40, 8'h50: cj(2'h2, 3'h2, op1, carry ^ op[4], 1'b1, e);
      8'h60, 8'h70: cj(2'h2, 3'h2, op1, (acc == 8'h00) ^ op[4], 1'b1, e);
      8'h20, 8'h30, 8'h10:
      begin
        cj(2'h3, 3'h3, op2, bitv ^ (op == 8'h30), 1'b1, e);
        bitop(e);
        e.clr = (op == 8'h10) & bitv;
      end
      8'b????0001: cj(2'h2, 3'h2, 8'h00, 1'b1, 1'b0, e);
      8'h12, 8'h02: cj(2'h3, 3'h3, 8'h00, 1'b1, 1'b0, e);
      8'h22, 8'h32: cj(2'h1, 3'h4, 8'h00, 1'b1, 1'b0, e);
      8'h80: cj(2'h2, 3'h2, op1, 1'b1, 1'b0, e);
      8'h73: cj(2'h1, 3'h2, 8'h00, 1'b1, 1'b0, e);
      8'hb5: cj(2'h3, 3'h3, op2, acc != operand, 1'b1, e);
      8'hb4: cj(2'h3, 3'h3, op2, acc != op1, 1'b1, e);
      8'b10111???:
      begin
        cj(2'h3, 3'h3, op2, operand != op1, 1'b1, e);
        e.ock = 1'b1;
        e.oa = {3'h0, program_status_word[4:3], op[2:0]};
        e.sp = 2'h1;
      end
      8'hb6, 8'hb7:
      begin
        cj(2'h3, 3'h4, op2, operand != op1, 1'b1, e);
        e.pck = 1'b1;
        e.pa = {3'h0, program_status_word[4:3], 2'h0, op[0]};
        e.ock = 1'b1;
        e.oa = ptr;
        e.sp = ptr[7] ? 2'h3 : 2'h1;
      end
      8'b11011???, 8'hd5:
      begin
        cj(op[3] ? 2'h2 : 2'h3, op[3] ? 3'h2 : 3'h3, op[3] ? op1 : op2, operand != 8'h01,
          1'b1, e);
        e.wck = 1'b1;
        e.wb = operand - 8'h01;
        e.ock = 1'b1;
        e.oa = {3'h0, program_status_word[4:3], op[2:0]};
        e.sp = 2'h1;
      end
      default: e.dec = 1'b0;
    endcase
    if (op[3:0] == 4'h1)
      e.npc = {e.npc[15:11], op[7:5], op1};
    if (op == 8'h12 || op == 8'h02)
      e.npc = {op1, op2};
    if (op == 8'h22 || op == 8'h32)
      e.npc = ra;
    if (op == 8'h73)
      e.npc = dp + {8'h00, acc};
    if (op == 8'hb5 || op == 8'hd5)
    begin
      e.ock = 1'b1;
      e.oa = op1;
      e.sp = op1[7] ? 2'h2 : 2'h1;
    end
    @(posedge sys_clk);
    e.t0 = $time;
    q.push_back(e);
    #1;
    if (done !== 1'b1)
    begin
      // Holding the request one more cycle while busy must be ignored.
      if (e.cyc > 3'h2 && r[4])
      begin
        @(posedge sys_clk);
        #1;
      end
      start = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 8)
      begin
        @(posedge sys_clk);
        #1;
        n++;
      end
    end
  endtask : issue

  always @(posedge sys_clk)
  begin
    #1;
    {xw, we} = go ? 2'(xorshift()) : 2'b00;
    nf += 16'(xw & we);
    nxd += 16'(xw & ~we);
  end

  always @(posedge sys_clk)
  begin
    xw_q <= xw;
    we_q <= we;
  end

  always @(negedge sys_clk)
  begin
    chk({fwr, xwr}, {xw_q & we_q, xw_q & ~we_q});
    if (done === 1'b1)
    begin
      if (q.size() == 0)
        chk(24'h1, 24'h0);
      else
      begin
        m = q.pop_front();
        chk(24'($time - m.t0), 24'(m.cyc - 3'h1) * 8 + 4);
        chk(busy, 1'b0);
        chk(decoded, m.dec);
        if (m.dec)
        begin
          chk(len, m.len);
          chk(cyc, m.cyc);
          chk(npc, m.npc);
          chk(pres, m.npc > 16'hfbff);
          chk(bacc, m.ba);
          chk(clrb, m.clr);
          if (m.tc)
            chk(tk, m.tk);
          if (m.ba)
            chk(bpos, m.bp);
          if (m.ock)
            chk({space, oaddr}, {m.sp, m.oa});
          if (m.pck)
            chk(paddr, m.pa);
          if (m.wck)
            chk(wb, m.wb);
        end
      end
    end
  end

  initial
  begin
    #200000;
    errors++;
    $display("FAIL %0t: watchdog expired", $time);
    complete_run();
  end

  initial
  begin
    repeat (5) @(posedge sys_clk);
    #1;
    chk({len, cyc, done, busy}, {2'h1, 3'h1, 2'h0});
    nrst = 1'b1;
    @(posedge sys_clk);
    #1;
    go = 1'b1;
    for (int i = 0; i < 400; i++)
      issue(i < 37 ? tbl[i] : tbl[xorshift() % 37]);
    start = 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    chk(24'(q.size()), 24'h0);
    $display("test branch decode done");
    go = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    chk({fcnt, 8'h00}, {nf, 8'h00});
    chk(xcnt, nxd);
    $display("test write steering done");
    complete_run();
  end
endmodule : cpu_branch_bit_memory_addressing_bench
